// file: pmt_pkg.sv
// Constants and carriers for the proximity measure and threshold block
package pmt_pkg;
    localparam logic [7:0] PMT_ADDR_PUP_HI = 8'h10;
    localparam logic [7:0] PMT_ADDR_PUP_LO = 8'h11;
    localparam logic [7:0] PMT_ADDR_PLO_HI = 8'h12;
    localparam logic [7:0] PMT_ADDR_PLO_LO = 8'h13;
    localparam logic [7:0] PMT_ADDR_FILT = 8'h14;
    localparam logic [7:0] PMT_ADDR_SETUP = 8'h15;
    localparam logic [7:0] PMT_ADDR_WAIT = 8'h16;
    localparam logic [7:0] PMT_ADDR_CTRL = 8'h17;
    localparam logic [7:0] PMT_ADDR_LUP_HI = 8'h20;
    localparam logic [7:0] PMT_ADDR_LUP_LO = 8'h21;
    localparam logic [7:0] PMT_RST_UP = 8'hff;
    localparam logic [7:0] PMT_RST_LO = 8'h00;
    localparam logic [7:0] PMT_RST_FILT = 8'h11;
    localparam logic [7:0] PMT_RST_SETUP = 8'h0b;
    localparam logic [7:0] PMT_RST_WAIT = 8'h04;
    localparam logic [7:0] PMT_RST_CTRL = 8'h00;
    localparam int PMT_BIT_HYST_EN = 5;
    localparam int PMT_BIT_HYST_UP = 4;
    localparam int PMT_BIT_BLANK = 3;
    localparam int PMT_BIT_REPEAT = 1;
    localparam int PMT_BIT_SINGLE = 0;
    localparam int PMT_CLK_NS = 40;
    localparam int PMT_LED_PERIOD_NS = 1500;
    localparam int PMT_LED_PERIOD_CYC = PMT_LED_PERIOD_NS / PMT_CLK_NS;
    localparam int PMT_WAIT_STEP_MS = 10;
    localparam int PMT_WAIT_STEP_CYC =
        PMT_WAIT_STEP_MS * 1000000 / PMT_CLK_NS;
    localparam int PMT_HIST_LEN = 15;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmt_reg_req_t;

    typedef struct packed {
        logic auto_clear;
        logic edge_mode;
        logic clear;
    } pmt_int_cfg_t;

    typedef struct packed {
        logic enable;
        logic upper;
    } pmt_hyst_t;

    function automatic logic [11:0] pulses_of(input logic [2:0] code);
        int us;
        case (code)
            3'h0: us = 150;
            3'h1: us = 300;
            3'h2: us = 600;
            3'h3: us = 1200;
            3'h4: us = 1800;
            3'h5: us = 2400;
            3'h6: us = 3600;
            default: us = 4800;
        endcase
        return 12'((us * 1000) / PMT_LED_PERIOD_NS);
    endfunction

    // Event test: window, or trigger side only under hysteresis
    function automatic logic beyond(input logic [15:0] v,
            input logic [15:0] up, input logic [15:0] lo,
            input logic hyst, input logic trig_up);
        if (hyst)
            return trig_up ? (v > up) : (v < lo);
        return (v > up) || (v < lo);
    endfunction

    function automatic logic released(input logic [15:0] v,
            input logic [15:0] up, input logic [15:0] lo,
            input logic trig_up);
        return trig_up ? (v <= lo) : (v >= up);
    endfunction

    function automatic logic [4:0] count_ones(input logic [14:0] h,
            input logic [3:0] n);
        logic [4:0] c;
        c = 5'h0;
        for (int i = 0; i < PMT_HIST_LEN; i++) begin
            if (i < int'(n) && h[i])
                c = c + 5'h1;
        end
        return c;
    endfunction
endpackage

// file: pmt_core.sv
// Proximity sequencer with threshold, filter and interrupt qualification
module pmt_core #(
    parameter int WAIT_STEP_CYC = pmt_pkg::PMT_WAIT_STEP_CYC,
    parameter int LED_PERIOD_CYC = pmt_pkg::PMT_LED_PERIOD_CYC
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Register port
    input wire pmt_pkg::pmt_reg_req_t i_reg,
    output logic [7:0] o_reg_rdata,
    // Interrupt setup and clear from the shared interrupt logic
    input wire pmt_pkg::pmt_int_cfg_t i_int_cfg,
    input wire pmt_pkg::pmt_hyst_t i_light_hyst,
    input wire logic [15:0] i_light_lower_thresh,
    // Front end results
    input wire logic [15:0] i_prox_result,
    input wire logic i_light_valid,
    input wire logic [15:0] i_photopic_result,
    // Front end control and interrupt outputs
    output logic o_led_drive,
    output logic o_sense_power,
    output logic o_light_blank,
    output logic o_meas_done,
    output logic o_prox_flag,
    output logic o_light_flag,
    output logic o_int_pin
);
    import pmt_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_WAIT} pmt_state_t;

    logic [7:0] pup_hi_reg, pup_lo_reg, plo_hi_reg, plo_lo_reg;
    logic [7:0] lup_hi_reg, lup_lo_reg;
    logic [7:0] filt_reg, setup_reg, wait_reg, ctrl_reg;
    logic [7:0] pend_reg;
    logic pend_valid_reg;
    pmt_state_t state_reg;
    logic [11:0] pulse_cnt_reg, pulse_total_reg;
    logic [11:0] period_cnt_reg;
    logic [31:0] step_cyc_reg;
    logic [6:0] step_cnt_reg;
    logic [14:0] hist_reg;
    logic prox_flag_reg, light_flag_reg, event_d_reg;
    logic [15:0] prox_up, prox_lo, light_up;
    logic prox_hyst, light_hyst, prox_hit, light_hit, filt_ok;
    logic done_now, wait_end, wr_ctrl;
    logic [14:0] hist_next;

    assign prox_up = {pup_hi_reg, pup_lo_reg};
    assign prox_lo = {plo_hi_reg, plo_lo_reg};
    assign light_up = {lup_hi_reg, lup_lo_reg};
    assign wr_ctrl = i_reg.wr && i_reg.addr == PMT_ADDR_CTRL;
    // Hysteresis only counts in automatic clearing mode
    assign prox_hyst = setup_reg[PMT_BIT_HYST_EN]
        && i_int_cfg.auto_clear;
    assign light_hyst = i_light_hyst.enable && i_int_cfg.auto_clear;
    assign prox_hit = beyond(i_prox_result, prox_up, prox_lo, prox_hyst,
        setup_reg[PMT_BIT_HYST_UP]);
    assign light_hit = beyond(i_photopic_result, light_up,
        i_light_lower_thresh, light_hyst, i_light_hyst.upper);
    assign hist_next = {hist_reg[13:0], prox_hit};
    assign filt_ok = filt_reg[3:0] != 4'h0 && filt_reg[7:4] != 4'h0
        && count_ones(hist_next, filt_reg[7:4])
        >= {1'b0, filt_reg[3:0]};
    assign done_now = state_reg == ST_MEAS
        && period_cnt_reg == 12'(LED_PERIOD_CYC - 1)
        && pulse_cnt_reg == pulse_total_reg - 12'h1;
    assign wait_end = step_cyc_reg == 32'(WAIT_STEP_CYC - 1)
        && step_cnt_reg == wait_reg[6:0];

    // Threshold and setup registers
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pup_hi_reg <= PMT_RST_UP;
            pup_lo_reg <= PMT_RST_UP;
            plo_hi_reg <= PMT_RST_LO;
            plo_lo_reg <= PMT_RST_LO;
            lup_hi_reg <= PMT_RST_UP;
            lup_lo_reg <= PMT_RST_UP;
            filt_reg <= PMT_RST_FILT;
            setup_reg <= PMT_RST_SETUP;
            wait_reg <= PMT_RST_WAIT;
        end else if (i_reg.wr) begin
            case (i_reg.addr)
                PMT_ADDR_PUP_HI: pup_hi_reg <= i_reg.wdata;
                PMT_ADDR_PUP_LO: pup_lo_reg <= i_reg.wdata;
                PMT_ADDR_PLO_HI: plo_hi_reg <= i_reg.wdata;
                PMT_ADDR_PLO_LO: plo_lo_reg <= i_reg.wdata;
                PMT_ADDR_LUP_HI: lup_hi_reg <= i_reg.wdata;
                PMT_ADDR_LUP_LO: lup_lo_reg <= i_reg.wdata;
                PMT_ADDR_FILT: filt_reg <= i_reg.wdata;
                PMT_ADDR_SETUP: setup_reg <= {2'h0, i_reg.wdata[5:0]};
                PMT_ADDR_WAIT: wait_reg <= {1'b0, i_reg.wdata[6:0]};
                default: ;
            endcase
        end
    end

    // Control: held back while measuring, then applied at the end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ctrl_reg <= PMT_RST_CTRL;
            pend_reg <= PMT_RST_CTRL;
            pend_valid_reg <= 1'b0;
        end else if (wr_ctrl && state_reg == ST_MEAS && !done_now) begin
            pend_reg <= {6'h0, i_reg.wdata[1:0]};
            pend_valid_reg <= 1'b1;
        end else if (wr_ctrl) begin
            ctrl_reg <= {6'h0, i_reg.wdata[1:0]};
            pend_valid_reg <= 1'b0;
        end else if (done_now) begin
            pend_valid_reg <= 1'b0;
            if (pend_valid_reg)
                ctrl_reg <= pend_reg;
            else if (!ctrl_reg[PMT_BIT_REPEAT])
                ctrl_reg[PMT_BIT_SINGLE] <= 1'b0;
        end
    end

    // Sequencer
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            pulse_cnt_reg <= 12'h0;
            pulse_total_reg <= 12'h1;
            period_cnt_reg <= 12'h0;
            step_cyc_reg <= 32'h0;
            step_cnt_reg <= 7'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (ctrl_reg[PMT_BIT_SINGLE]
                            || ctrl_reg[PMT_BIT_REPEAT]) begin
                        state_reg <= ST_MEAS;
                        pulse_total_reg <= pulses_of(setup_reg[2:0]);
                        pulse_cnt_reg <= 12'h0;
                        period_cnt_reg <= 12'h0;
                    end
                end
                ST_MEAS: begin
                    if (period_cnt_reg == 12'(LED_PERIOD_CYC - 1)) begin
                        period_cnt_reg <= 12'h0;
                        pulse_cnt_reg <= pulse_cnt_reg + 12'h1;
                    end else begin
                        period_cnt_reg <= period_cnt_reg + 12'h1;
                    end
                    if (done_now) begin
                        step_cyc_reg <= 32'h0;
                        step_cnt_reg <= 7'h0;
                        if (ctrl_reg[PMT_BIT_REPEAT])
                            state_reg <= ST_WAIT;
                        else
                            state_reg <= ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    if (step_cyc_reg == 32'(WAIT_STEP_CYC - 1)) begin
                        step_cyc_reg <= 32'h0;
                        step_cnt_reg <= step_cnt_reg + 7'h1;
                    end else begin
                        step_cyc_reg <= step_cyc_reg + 32'h1;
                    end
                    if (wait_end) begin
                        pulse_total_reg <= pulses_of(setup_reg[2:0]);
                        pulse_cnt_reg <= 12'h0;
                        period_cnt_reg <= 12'h0;
                        if (ctrl_reg[PMT_BIT_REPEAT])
                            state_reg <= ST_MEAS;
                        else
                            state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Front end drive; LED high for the first half of each period
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_led_drive <= 1'b0;
            o_sense_power <= 1'b0;
            o_light_blank <= 1'b0;
            o_meas_done <= 1'b0;
        end else begin
            o_led_drive <= state_reg == ST_MEAS && !done_now
                && period_cnt_reg < 12'(LED_PERIOD_CYC / 2);
            o_sense_power <= state_reg == ST_MEAS && !done_now;
            // Blank the whole measurement so LED edges never leak in
            o_light_blank <= setup_reg[PMT_BIT_BLANK]
                && state_reg == ST_MEAS && !done_now;
            o_meas_done <= done_now;
        end
    end

    // Filter history
    always_ff @(posedge i_clock) begin
        if (i_reset || (i_reg.wr && i_reg.addr == PMT_ADDR_FILT))
            hist_reg <= 15'h0;
        else if (done_now)
            hist_reg <= hist_next;
    end

    // Proximity flag; a new event beats a clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_reset)
            prox_flag_reg <= 1'b0;
        else if (done_now && filt_ok)
            prox_flag_reg <= 1'b1;
        else if (done_now && i_int_cfg.auto_clear && !prox_hyst)
            prox_flag_reg <= 1'b0;
        else if (done_now && prox_hyst && released(i_prox_result,
                prox_up, prox_lo, setup_reg[PMT_BIT_HYST_UP]))
            prox_flag_reg <= 1'b0;
        else if (!i_int_cfg.auto_clear && i_int_cfg.clear)
            prox_flag_reg <= 1'b0;
    end

    // Light flag
    always_ff @(posedge i_clock) begin
        if (i_reset)
            light_flag_reg <= 1'b0;
        else if (i_light_valid && light_hit)
            light_flag_reg <= 1'b1;
        else if (i_light_valid && i_int_cfg.auto_clear && !light_hyst)
            light_flag_reg <= 1'b0;
        else if (i_light_valid && light_hyst && released(i_photopic_result,
                light_up, i_light_lower_thresh, i_light_hyst.upper))
            light_flag_reg <= 1'b0;
        else if (!i_int_cfg.auto_clear && i_int_cfg.clear)
            light_flag_reg <= 1'b0;
    end

    // Pin follows flags one cycle later; in edge mode it pulses for one cycle per result only
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            event_d_reg <= 1'b0;
            o_int_pin <= 1'b0;
        end else begin
            event_d_reg <= done_now || i_light_valid;
            if (i_int_cfg.edge_mode)
                o_int_pin <= event_d_reg
                    && (prox_flag_reg || light_flag_reg);
            else
                o_int_pin <= prox_flag_reg || light_flag_reg;
        end
    end

    assign o_prox_flag = prox_flag_reg;
    assign o_light_flag = light_flag_reg;

    // Read data, unmapped reads give zero
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg.rd) begin
            case (i_reg.addr)
                PMT_ADDR_PUP_HI: o_reg_rdata <= pup_hi_reg;
                PMT_ADDR_PUP_LO: o_reg_rdata <= pup_lo_reg;
                PMT_ADDR_PLO_HI: o_reg_rdata <= plo_hi_reg;
                PMT_ADDR_PLO_LO: o_reg_rdata <= plo_lo_reg;
                PMT_ADDR_LUP_HI: o_reg_rdata <= lup_hi_reg;
                PMT_ADDR_LUP_LO: o_reg_rdata <= lup_lo_reg;
                PMT_ADDR_FILT: o_reg_rdata <= filt_reg;
                PMT_ADDR_SETUP: o_reg_rdata <= setup_reg;
                PMT_ADDR_WAIT: o_reg_rdata <= wait_reg;
                PMT_ADDR_CTRL: o_reg_rdata <= ctrl_reg;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence meas_end_s;
        done_now ##1 !o_sense_power;
    endsequence
    sequence meas_start_s;
        state_reg == ST_IDLE ##1 state_reg == ST_MEAS;
    endsequence

    up_reset_a: assert property (@(posedge i_clock) disable iff (1'b0)
        i_reset |=> prox_up == 16'hffff && light_up == 16'hffff)
        else $error("upper thresholds not all ones after reset");
    lo_reset_a: assert property (@(posedge i_clock) disable iff (1'b0)
        i_reset |=> prox_lo == 16'h0000 && filt_reg == PMT_RST_FILT)
        else $error("lower threshold or filter wrong after reset");
    filter_zero_a: assert property (
        done_now && (filt_reg[3:0] == 4'h0 || filt_reg[7:4] == 4'h0)
            && !prox_flag_reg |=> !prox_flag_reg)
        else $error("flag set with filter count zero");
    pulse_total_a: assert property (
        meas_start_s |-> pulse_total_reg == pulses_of($past(setup_reg[2:0])))
        else $error("pulse total does not match integration code");
    power_down_a: assert property (done_now |-> meas_end_s)
        else $error("sensing still powered after measurement");
    blank_led_a: assert property (
        o_led_drive && setup_reg[PMT_BIT_BLANK] && !$past(i_reg.wr)
            |-> o_light_blank)
        else $error("light not blanked while LED driven");
    repeat_wait_a: assert property (
        done_now && ctrl_reg[PMT_BIT_REPEAT] && !wr_ctrl
            && !pend_valid_reg |=> state_reg == ST_WAIT [*2])
        else $error("repeat mode did not wait");
    single_clear_a: assert property (
        done_now && !ctrl_reg[PMT_BIT_REPEAT] && !pend_valid_reg && !wr_ctrl
            |=> !ctrl_reg[PMT_BIT_SINGLE] && state_reg == ST_IDLE)
        else $error("single run bit not cleared after measurement");
    ctrl_hold_a: assert property (
        state_reg == ST_MEAS && !done_now |=> $stable(ctrl_reg))
        else $error("control changed during measurement");
endmodule

// file: pmt_host.sv
// Host model that drives the register strobe port
module pmt_host (
    // Clock
    input wire logic i_clock,
    // Register port
    output pmt_pkg::pmt_reg_req_t o_reg,
    input wire logic [7:0] i_reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmt_pkg::*;
    initial o_reg = '0;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clock);
        #1;
        // Released fields do not keep the old value
        o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clock);
        #1;
        o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h00};
        d = i_reg_rdata;
    endtask
endmodule

// file: pmt_core_tb.sv
// Self-checking bench for the proximity measure and threshold block
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    error_cnt++; $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end end
module pmt_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmt_pkg::*;
    localparam int STEP = 20;
    localparam int LEDP = 4;
    logic i_clock, i_reset, i_light_valid;
    pmt_reg_req_t req;
    pmt_int_cfg_t i_int_cfg;
    pmt_hyst_t i_light_hyst;
    logic [15:0] i_light_lower_thresh, i_prox_result, i_photopic_result;
    logic [7:0] rdata, rd;
    logic led, sense, blank, done, pflag, lflag, pin;
    int error_cnt = 0;
    int checks = 0;
    int pulses, pins, gap;
    logic blank_seen;
    pmt_core #(.WAIT_STEP_CYC(STEP), .LED_PERIOD_CYC(LEDP)) dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_reg(req),
        .o_reg_rdata(rdata), .i_int_cfg(i_int_cfg),
        .i_light_hyst(i_light_hyst),
        .i_light_lower_thresh(i_light_lower_thresh),
        .i_prox_result(i_prox_result), .i_light_valid(i_light_valid),
        .i_photopic_result(i_photopic_result), .o_led_drive(led),
        .o_sense_power(sense), .o_light_blank(blank), .o_meas_done(done),
        .o_prox_flag(pflag), .o_light_flag(lflag), .o_int_pin(pin));
    pmt_host host (.i_clock(i_clock), .o_reg(req), .i_reg_rdata(rdata));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_done();
        int n;
        logic prev;
        n = 0;
        prev = led;
        while (done !== 1'b1) begin
            @(posedge i_clock);
            #1;
            pulses += (led === 1'b1 && prev !== 1'b1) ? 1 : 0;
            prev = led;
            blank_seen |= (blank === 1'b1);
            if (++n > 20000) begin
                error_cnt++;
                tally_and_finish();
            end
        end
    endtask
    // One single-shot measurement with the given result
    task automatic measure(input logic [15:0] res);
        i_prox_result = res;
        pulses = 0;
        blank_seen = 1'b0;
        host.write_reg(PMT_ADDR_CTRL, 8'h01);
        wait_done();
        pins = 0;
        repeat (4) begin
            @(posedge i_clock);
            #1;
            pins += (pin === 1'b1) ? 1 : 0;
        end
        `CHK("sense_off", 1'b0, sense)
        `CHK("led_off", 1'b0, led)
    endtask
    task automatic light(input logic [15:0] res, input logic exp);
        @(posedge i_clock);
        #1;
        i_photopic_result = res;
        i_light_valid = 1'b1;
        @(posedge i_clock);
        #1;
        i_light_valid = 1'b0;
        i_photopic_result = ~res;
        repeat (2) @(posedge i_clock);
        #1;
        `CHK("light_flag", exp, lflag)
    endtask
    logic [7:0] adr [11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h16, 8'h17, 8'h20, 8'h21, 8'h30};
    logic [7:0] rst [11] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h11, 8'h0b,
        8'h04, 8'h00, 8'hff, 8'hff, 8'h00};
    int npul [8] = '{100, 200, 400, 800, 1200, 1600, 2400, 3200};
    initial begin
        i_reset = 1'b1;
        i_int_cfg = '{auto_clear: 1'b1, edge_mode: 1'b0, clear: 1'b0};
        i_light_hyst = '0;
        i_light_lower_thresh = 16'h0100;
        i_prox_result = 16'h0000;
        i_light_valid = 1'b0;
        i_photopic_result = 16'h0000;
        repeat (16) @(posedge i_clock);
        #1;
        i_reset = 1'b0;
        for (int i = 0; i < 11; i++) begin
            host.read_reg(adr[i], rd);
            `CHK("reset_value", rst[i], rd)
        end
        $display("test reset values done");
        host.write_reg(PMT_ADDR_SETUP, 8'hff);
        host.read_reg(PMT_ADDR_SETUP, rd);
        `CHK("setup_rw", 8'h3f, rd)
        host.write_reg(PMT_ADDR_WAIT, 8'hff);
        host.read_reg(PMT_ADDR_WAIT, rd);
        `CHK("wait_rw", 8'h7f, rd)
        host.write_reg(PMT_ADDR_PUP_HI, 8'h01);
        host.write_reg(PMT_ADDR_PUP_LO, 8'h00);
        host.write_reg(PMT_ADDR_PLO_LO, 8'h40);
        host.read_reg(PMT_ADDR_PLO_LO, rd);
        `CHK("lower_lo_rw", 8'h40, rd)
        $display("test register access done");
        // Every integration code, blanking off, result inside window
        for (int c = 0; c < 8; c++) begin
            host.write_reg(PMT_ADDR_SETUP, 8'(c));
            measure(16'h0080);
            `CHK("led_pulses", npul[c], pulses)
            `CHK("blank_off", 1'b0, blank_seen)
            `CHK("flag_in_window", 1'b0, pflag)
        end
        host.write_reg(PMT_ADDR_SETUP, 8'h08);
        measure(16'h0200);
        `CHK("blank_on", 1'b1, blank_seen)
        `CHK("prox_flag", 1'b1, pflag)
        `CHK("pin_level", 1'b1, pin)
        host.read_reg(PMT_ADDR_CTRL, rd);
        `CHK("single_clear", 8'h00, rd)
        i_int_cfg.edge_mode = 1'b1;
        measure(16'h0200);
        `CHK("pin_edge", 1, pins)
        i_int_cfg.edge_mode = 1'b0;
        $display("test single shot done");
        host.write_reg(PMT_ADDR_FILT, 8'h10);
        measure(16'h0200);
        `CHK("filter_zero", 1'b0, pflag)
        measure(16'h0200);
        `CHK("filter_zero_again", 1'b0, pflag)
        host.write_reg(PMT_ADDR_FILT, 8'h32);
        measure(16'h0200);
        `CHK("filter_first", 1'b0, pflag)
        measure(16'h0200);
        `CHK("filter_second", 1'b1, pflag)
        host.write_reg(PMT_ADDR_FILT, 8'h32);
        measure(16'h0200);
        `CHK("filter_cleared", 1'b0, pflag)
        host.write_reg(PMT_ADDR_FILT, 8'h11);
        $display("test filter done");
        host.write_reg(PMT_ADDR_SETUP, 8'h38);
        measure(16'h0200);
        `CHK("hyst_set", 1'b1, pflag)
        measure(16'h0080);
        `CHK("hyst_hold", 1'b1, pflag)
        measure(16'h0040);
        `CHK("hyst_clear", 1'b0, pflag)
        host.write_reg(PMT_ADDR_SETUP, 8'h28);
        measure(16'h0000);
        `CHK("hyst_low_set", 1'b1, pflag)
        host.write_reg(PMT_ADDR_SETUP, 8'h08);
        $display("test hysteresis done");
        host.write_reg(PMT_ADDR_WAIT, 8'h01);
        host.write_reg(PMT_ADDR_CTRL, 8'h02);
        wait_done();
        gap = 0;
        while (sense !== 1'b1) begin
            @(posedge i_clock);
            #1;
            if (++gap > 200) begin
                error_cnt++;
                tally_and_finish();
            end
        end
        gap = gap - 2 * STEP;
        `CHK("repeat_gap", 1'b1, gap >= 0 && gap <= 2)
        host.write_reg(PMT_ADDR_CTRL, 8'h00);
        host.read_reg(PMT_ADDR_CTRL, rd);
        `CHK("ctrl_pending", 8'h02, rd)
        wait_done();
        repeat (3 * STEP) @(posedge i_clock);
        #1;
        host.read_reg(PMT_ADDR_CTRL, rd);
        `CHK("ctrl_applied", 8'h00, rd)
        `CHK("repeat_stopped", 1'b0, sense)
        $display("test repeat done");
        host.write_reg(PMT_ADDR_LUP_HI, 8'h10);
        host.write_reg(PMT_ADDR_LUP_LO, 8'h00);
        light(16'h2000, 1'b1);
        light(16'h0800, 1'b0);
        i_light_hyst = '{enable: 1'b1, upper: 1'b1};
        light(16'h2000, 1'b1);
        light(16'h0800, 1'b1);
        light(16'h0080, 1'b0);
        i_light_hyst.upper = 1'b0;
        light(16'h0080, 1'b1);
        light(16'h0800, 1'b1);
        light(16'h2000, 1'b0);
        // Latched: window applies despite hysteresis, only clear drops flags
        i_int_cfg.auto_clear = 1'b0;
        light(16'h2000, 1'b1);
        light(16'h0800, 1'b1);
        i_int_cfg.clear = 1'b1;
        @(posedge i_clock);
        #1;
        i_int_cfg.clear = 1'b0;
        @(posedge i_clock);
        #1;
        `CHK("latched_clear", 1'b0, lflag)
        `CHK("prox_clear", 1'b0, pflag)
        $display("test light done");
        tally_and_finish();
    end
endmodule
